//--- src/pcm_time_slot_interface.sv
// pcm highway time slot interface for four channels, tx and rx on separate pins
// assumes bit clock and frame strobe are synchronous, both well below the system clock
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - every frame strobe restarts the frame for all four channels together.
// - a frame is cut into slots of eight bit clocks and each channel moves its sample in its own slot.
// - transmit and receive slots are set per channel, independently, to any slot.
// - bit clocks up to 16.384 Mbit/s give up to 256 slots, and slower clocks also work.
// - transmit and receive data use separate pins for a four-wire highway.
// - a mode input picks mu-law or a-law coding of the highway samples.
// - the transmit pin is three-state so several devices may share the line.
// - all logic is reset while the chip reset is low.
module pcm_time_slot_interface
  import pcm_tsi_pkg::*;
#(
  parameter int unsigned channels = num_channels
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic bit_clock_in,
  input wire logic frame_sync_in,
  input wire logic pcm_rx_in,
  output logic pcm_tx_out,
  output logic pcm_tx_oe_n,
  input wire logic alaw_select,
  input wire logic [channels*slot_index_w-1:0] tx_slot,
  input wire logic [channels*slot_index_w-1:0] rx_slot,
  input wire logic [channels*slot_bits-1:0] tx_sample,
  output logic [channels*slot_bits-1:0] rx_sample,
  output logic [channels-1:0] rx_sample_valid,
  output logic [channels-1:0] tx_sample_taken
);

  typedef struct packed {
    logic [1:0] bclk_sync;
    logic [1:0] fs_sync;
    logic [1:0] rx_sync;
    logic bclk_prev;
    logic fs_prev;
    logic fs_pending;
    logic [slot_index_w-1:0] slot;
    logic [bit_index_w-1:0] bit_idx;
    logic [channels*slot_bits-1:0] tx_shift;
    logic [channels*slot_bits-1:0] rx_shift;
    logic [channels*slot_bits-1:0] rx_out;
    logic [channels-1:0] rx_valid;
    logic [channels-1:0] tx_taken;
    logic tx_data;
    logic tx_oe_n;
  } state_t;

  state_t s_q;
  state_t s_d;

  // mu-law highway bytes are sent inverted, a-law with even bits inverted
  function automatic logic [7:0] to_line(input logic [7:0] v, input logic alaw);
    to_line = alaw ? (v ^ alaw_invert_mask) : ~v;
  endfunction : to_line

  // pin edges, seen only on the synchronised copies
  logic bclk_rise;
  logic bclk_fall;
  logic fs_rise;
  logic frame_restart;

  always_comb
  begin
    bclk_rise = s_q.bclk_sync[1] && !s_q.bclk_prev;
    bclk_fall = !s_q.bclk_sync[1] && s_q.bclk_prev;
    fs_rise = s_q.fs_sync[1] && !s_q.fs_prev;
    // a strobe now or still pending makes the next rising edge slot 0 bit 0
    frame_restart = s_q.fs_pending || fs_rise;
  end

  // slot and bit handled at this bit clock edge
  logic [slot_index_w-1:0] cur_slot;
  logic [bit_index_w-1:0] cur_bit;
  logic first_bit;
  logic last_bit;
  logic [slot_index_w-1:0] next_slot;
  logic [bit_index_w-1:0] next_bit;

  always_comb
  begin
    // the fall before slot 0 needs the restart as well, or the first
    // bit of a fresh frame would come from stale counters
    cur_slot = frame_restart ? slot_reset : s_q.slot;
    cur_bit = frame_restart ? bit_reset : s_q.bit_idx;
    first_bit = (cur_bit == bit_reset);
    last_bit = (cur_bit == bit_index_w'(slot_bits-1));
    // 8-bit slot counter wraps at 256 slots; slower clocks leave later slots unused
    next_bit = cur_bit + bit_index_w'(1);
    next_slot = last_bit ? cur_slot + slot_index_w'(1) : cur_slot;
  end

  // per-channel slot match and coded bytes
  logic [channels-1:0] tx_hit;
  logic [channels-1:0] rx_hit;
  logic [slot_bits-1:0] tx_line [channels];
  logic [slot_bits-1:0] rx_next [channels];
  logic [slot_bits-1:0] rx_line [channels];

  for (genvar c = 0; c < channels; c++)
  begin : g_chan
    assign tx_hit[c] = (tx_slot[c*slot_index_w +: slot_index_w] == cur_slot);
    assign rx_hit[c] = (rx_slot[c*slot_index_w +: slot_index_w] == cur_slot);
    // tx byte is coded once, when its slot starts
    assign tx_line[c] = to_line(tx_sample[c*slot_bits +: slot_bits], alaw_select);
    // rx taken msb first on its own pin
    assign rx_next[c] = {s_q.rx_shift[c*slot_bits +: slot_bits-1], s_q.rx_sync[1]};
    assign rx_line[c] = to_line(rx_next[c], alaw_select);
  end

  // receive side: what the current rising edge does to every channel
  logic [channels*slot_bits-1:0] rx_shift_upd;
  logic [channels*slot_bits-1:0] rx_out_upd;
  logic [channels-1:0] rx_done;

  always_comb
  begin
    rx_shift_upd = s_q.rx_shift;
    rx_out_upd = s_q.rx_out;
    rx_done = '0;
    // channels sharing an rx slot all receive the same byte
    for (int c = 0; c < channels; c++)
    begin
      if (rx_hit[c])
      begin
        rx_shift_upd[c*slot_bits +: slot_bits] = rx_next[c];
        if (last_bit)
        begin
          rx_out_upd[c*slot_bits +: slot_bits] = rx_line[c];
          rx_done[c] = 1'b1;
        end
      end
    end
  end

  // transmit side: what the current falling edge puts on the pin
  logic [channels*slot_bits-1:0] tx_shift_upd;
  logic [channels-1:0] tx_load;
  logic tx_bit;
  logic tx_drive;

  always_comb
  begin
    tx_shift_upd = s_q.tx_shift;
    tx_load = '0;
    tx_bit = 1'b0;
    tx_drive = 1'b0;
    // a shared slot goes to the highest channel: the later pass wins
    for (int c = 0; c < channels; c++)
    begin
      if (tx_hit[c])
      begin
        if (first_bit)
        begin
          tx_shift_upd[c*slot_bits +: slot_bits] = tx_line[c];
          tx_load[c] = 1'b1;
        end
        // bit 0 reads the byte just loaded, not the old shift register
        tx_bit = tx_shift_upd[c*slot_bits + slot_bits - 1 - int'(cur_bit)];
        tx_drive = 1'b1;
      end
    end
  end

  always_comb
  begin
    s_d = s_q;
    // pins pass two flops before any logic reads them
    s_d.bclk_sync = {s_q.bclk_sync[0], bit_clock_in};
    s_d.fs_sync = {s_q.fs_sync[0], frame_sync_in};
    s_d.rx_sync = {s_q.rx_sync[0], pcm_rx_in};
    s_d.bclk_prev = s_q.bclk_sync[1];
    s_d.fs_prev = s_q.fs_sync[1];
    s_d.rx_valid = '0;
    s_d.tx_taken = '0;
    // strobe is held until the next rising bit clock edge
    if (fs_rise)
    begin
      s_d.fs_pending = 1'b1;
    end
    if (bclk_rise)
    begin
      s_d.rx_shift = rx_shift_upd;
      s_d.rx_out = rx_out_upd;
      s_d.rx_valid = rx_done;
      s_d.bit_idx = next_bit;
      s_d.slot = next_slot;
      s_d.fs_pending = 1'b0;
    end
    // tx launched on the fall before the rising edge that samples it
    if (bclk_fall)
    begin
      s_d.tx_shift = tx_shift_upd;
      s_d.tx_taken = tx_load;
      s_d.tx_data = tx_bit;
      s_d.tx_oe_n = !tx_drive;
    end
    if (!resetn)
    begin
      s_d = '0;
      s_d.tx_oe_n = 1'b1;
      s_d.rx_out = {channels{sample_reset}};
    end
  end

  always_ff @(posedge clock)
  begin
    s_q <= s_d;
  end

  assign pcm_tx_out = s_q.tx_data;
  assign pcm_tx_oe_n = s_q.tx_oe_n;
  assign rx_sample = s_q.rx_out;
  assign rx_sample_valid = s_q.rx_valid;
  assign tx_sample_taken = s_q.tx_taken;

endmodule : pcm_time_slot_interface
`default_nettype wire

//--- src/pcm_tsi_pkg.sv
// constants for the four-channel pcm time slot interface
// assumes a bit clock and frame strobe from the highway, sampled on the system clock
package pcm_tsi_pkg;
  localparam int unsigned num_channels = 4;
  localparam int unsigned slot_bits = 8;
  localparam int unsigned max_slots = 256;
  localparam int unsigned slot_index_w = 8;
  localparam int unsigned bit_index_w = 3;
  localparam int unsigned clock_mhz = 125;
  localparam int unsigned frame_rate_khz = 8;
  localparam int unsigned max_bit_rate_kbps = 16384;
  localparam logic [7:0] sample_reset = 8'hff;
  localparam logic [7:0] alaw_invert_mask = 8'h55;
  localparam logic [7:0] slot_reset = 8'h00;
  localparam logic [2:0] bit_reset = 3'h0;
  localparam logic [1:0] sync_reset = 2'h0;
endpackage : pcm_tsi_pkg

//--- sim/pcm_tsi_sva.sv
// port checks for the slot interface
// bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module pcm_tsi_sva #(parameter int unsigned channels = 4)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic pcm_tx_out,
  input wire logic pcm_tx_oe_n,
  input wire logic [channels*8-1:0] rx_sample,
  input wire logic [channels-1:0] rx_sample_valid,
  input wire logic [channels-1:0] tx_sample_taken
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  rst_float_a: assert property (disable iff (1'b0)
    !resetn |=> pcm_tx_oe_n && !pcm_tx_out) else $error("tx not idle in reset");
  rst_rx_a: assert property (disable iff (1'b0)
    !resetn |=> &rx_sample && !(|{rx_sample_valid, tx_sample_taken})) else $error("rx reset");
  float_low_a: assert property (pcm_tx_oe_n |-> !pcm_tx_out)
    else $error("data while floating");
  slot_len_a: assert property ($fell(pcm_tx_oe_n) |=> !pcm_tx_oe_n [*8])
    else $error("slot drive too short");
  bit_hold_a: assert property ($changed(pcm_tx_out) |=> $stable(pcm_tx_out) [*3])
    else $error("tx bit too short");
  take_drive_a: assert property (|tx_sample_taken |-> ##[0:2] !pcm_tx_oe_n)
    else $error("taken without drive");
  own_slot_a: assert property ($fell(pcm_tx_oe_n) |->
    |{tx_sample_taken, $past(tx_sample_taken), $past(tx_sample_taken, 2)}) else $error("stray drive");
  rx_upd_a: assert property ($changed(rx_sample) |-> ##[0:1] |rx_sample_valid)
    else $error("rx change without valid");
  cover property (|tx_sample_taken);
  cover property (|rx_sample_valid);
  cover property ($rose(pcm_tx_oe_n));
endmodule : pcm_tsi_sva
`default_nettype wire

//--- sim/pcm_highway_model.sv
// highway controller: bit clock, frame strobe, rx data, tx capture
// bit clock stands still between frames; slot s sends s^3c
`timescale 1ns/1ps
`default_nettype none
module pcm_highway_model
(
  output logic bclk,
  output logic fs,
  output logic rxd,
  input wire logic txd,
  input wire logic txd_oe_n
);
  logic [255:0][7:0] got;
  logic [255:0] drv;
  initial {bclk, fs, rxd} = 3'h4;
  task automatic cap(int j);
    if (!txd_oe_n)
    begin
      got[j[10:3]][~j[2:0]] = txd;
      drv[j[10:3]] = 1'b1;
    end
  endtask : cap
  // 64 ns bit: near the top rate, 256 slots per frame; clock idles high
  task automatic run_frame();
    logic [7:0] b;
    drv = '0;
    fs = 1'b1;
    for (int i = 0; i < 2048; i++)
    begin
      b = i[10:3] ^ 8'h3c;
      bclk = 1'b0;
      rxd = b[~i[2:0]];
      // tx bit i stands at the rising edge that takes it
      #32 cap(i);
      bclk = 1'b1;
      #32 fs = 1'b0;
    end
  endtask : run_frame
endmodule : pcm_highway_model
`default_nettype wire

//--- sim/pcm_time_slot_interface_test.sv
// bench for the slot interface with a highway model
// one frame per scenario, except reset which runs none
`timescale 1ns/1ps
`default_nettype none
module pcm_time_slot_interface_test;
  import pcm_tsi_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, alaw;
  logic [31:0] tx_slot, rx_slot, tx_sample, rx_sample;
  logic [3:0] rx_sample_valid, tx_sample_taken;
  wire logic bclk, fs, rxd, pcm_tx_out, pcm_tx_oe_n;
  int failures = 0, n_tests = 0, cyc = 0;
  pcm_time_slot_interface i_pcm_time_slot_interface (.clock, .resetn, .bit_clock_in(bclk),
    .frame_sync_in(fs), .pcm_rx_in(rxd), .pcm_tx_out, .pcm_tx_oe_n, .alaw_select(alaw),
    .tx_slot, .rx_slot, .tx_sample, .rx_sample, .rx_sample_valid, .tx_sample_taken);
  pcm_highway_model i_pcm_highway_model (.bclk, .fs, .rxd, .txd(pcm_tx_out),
    .txd_oe_n(pcm_tx_oe_n));
  int n_take [4];
  int n_valid [4];
  always @(negedge clock)
  begin
    for (int c = 0; c < 4; c++)
    begin
      n_take[c] += int'(tx_sample_taken[c]);
      n_valid[c] += int'(rx_sample_valid[c]);
    end
  end
  initial forever #4 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic check(string what, logic [255:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic run(logic law, logic [31:0] ts, rs, sm);
    logic [255:0] own;
    logic [7:0] m;
    @(negedge clock);
    {alaw, tx_slot, rx_slot, tx_sample} = {law, ts, rs, sm};
    own = '0;
    m = law ? alaw_invert_mask : 8'hff;
    n_take = '{default: 0};
    n_valid = '{default: 0};
    i_pcm_highway_model.run_frame();
    for (int c = 0; c < 4; c++)
    begin
      own[ts[8*c+:8]] = 1'b1;
      check("tx", i_pcm_highway_model.got[ts[8*c+:8]], sm[8*c+:8] ^ m);
      check("rx", rx_sample[8*c+:8], rs[8*c+:8] ^ 8'h3c ^ m);
      check("taken", n_take[c], 1);
      check("valid", n_valid[c], 1);
    end
    check("driven", i_pcm_highway_model.drv, own);
  endtask : run
  // adjacent slots, slot 255, shared rx slot
  task automatic scen_edges();
    run(1'b0, 32'hff800100, 32'h070700ff, 32'h12a5c33f);
  endtask : scen_edges
  task automatic scen_reset();
    @(negedge clock);
    resetn = 1'b0;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    check("reset", {rx_sample, pcm_tx_oe_n, pcm_tx_out}, {32'hffffffff, 2'h2});
  endtask : scen_reset
  task automatic scen_alaw();
    run(1'b1, 32'h03020100, 32'h00010203, 32'h00ff5a81);
  endtask : scen_alaw
  task automatic close_out();
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    {alaw, tx_slot, rx_slot, tx_sample} = '0;
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    check("idle", {rx_sample, pcm_tx_oe_n, pcm_tx_out}, {32'hffffffff, 2'h2});
    scen_edges();
    scen_reset();
    scen_alaw();
    close_out();
  end
endmodule : pcm_time_slot_interface_test
bind pcm_time_slot_interface pcm_tsi_sva #(.channels(channels)) i_pcm_tsi_sva (.clock, .resetn,
  .pcm_tx_out, .pcm_tx_oe_n, .rx_sample, .rx_sample_valid, .tx_sample_taken);
`default_nettype wire
